// ---- core/timer_cfg_map.vh ----
// Register map, field positions and reset values of the timer configuration bank.
// Assumes a byte-wide register port driven by the core on the master clock.
// Operation
// (RULE1) Divider code divides source clock by power two
// (RULE2) Bit five picks pulse or square wave
// (RULE3) Timer 0 reset source: internal, external, either
// (RULE4) Timer 0 start source: internal, external, either
// (RULE5) Only timer 0 may use external clock
// (RULE6) Sync hold bits five, six, seven
// (RULE7) Sync hold set keeps timer in reset
// (RULE8) Timers 1, 2 bit zero releases reset
// (RULE9) Timers 1, 2 bit two starts counting
// (RULE10) Interrupt edge: falling, rising, both
// (RULE11) Interrupt source: counter stop or output edges
// (RULE12) Mode bit seven selects PWM operation
// (RULE13) Pulse lasts one divided clock period
// (RULE14) Unused bits read zero; reserved codes unused
// (RULE15) All registers clear to zero on reset
`ifndef TIMER_CFG_MAP_VH
`define TIMER_CFG_MAP_VH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_T0_DIV      4'h0
`define ADDR_T0_SRC      4'h1
`define ADDR_T1_CTRL     4'h2
`define ADDR_T1_DIV      4'h3
`define ADDR_T2_CTRL     4'h4
`define ADDR_T2_DIV      4'h5
`define ADDR_IRQ_STATUS  4'h6
`define ADDR_IRQ_MASK    4'h7
// ----------------------------------------------------------------------------
// Field masks and values
// ----------------------------------------------------------------------------
`define DIV_REG_MASK     8'h3F
`define SRC_REG_MASK     8'hFF
`define CTRL_REG_MASK    8'hF5
`define IRQ_REG_MASK     8'h07
`define DIV_CODE_MAX     5'h10
`define SEL_INTERNAL     2'h0
`define SEL_EXTERNAL     2'h1
`define SEL_EITHER       2'h2
`define EDGE_FALL        2'h0
`define EDGE_RISE        2'h1
`define EDGE_BOTH        2'h2
`define REG_RESET        8'h00
`endif

// ---- core/timer_cfg.v ----
// Configuration bank and divided clock enables for three timer units; only timers 1 and 2 can select PWM.
// Assumes a synchronous register port and pins synchronous to clk_in.
`include "timer_cfg_map.vh"

module timer_cfg #(
   parameter DIV_WIDTH = 16                            // prescaler width; the counter has DIV_WIDTH+1 bits
) (
   input  wire       clk_in,                           // master clock
   input  wire       reset_in,                         // synchronous reset, high
   input  wire [3:0] addr_in,                          // register address
   input  wire [7:0] wdata_in,                         // write data
   input  wire       wr_in,                            // write strobe
   input  wire       rd_in,                            // read strobe
   output reg  [7:0] rdata_out,                        // read data, next cycle
   input  wire       ext_clock_in,                     // timer 0 external clock pin
   input  wire       ext_reset_in,                     // timer 0 external reset
   input  wire       ext_start_in,                     // timer 0 external start
   input  wire       timer0_internal_reset_in,         // timer 0 internal release
   input  wire       timer0_internal_start_in,         // timer 0 internal start
   input  wire [2:0] counter_stop_in,                  // counter stop events
   input  wire [2:0] timer_wave_in,                    // datapath terminal pulses
   output wire [2:0] tick_out,                         // divided clock enables
   output wire [2:0] run_enable_out,                   // timer out of reset
   output wire [2:0] go_out,                           // timer counting
   output wire [2:0] pwm_select_out,                   // PWM mode per timer
   output reg  [2:0] wave_out,                         // timer outputs
   output wire       irq_out                           // level interrupt
);

   reg  [7:0] t0_div;
   reg  [7:0] t0_src;
   reg  [7:0] t1_ctrl;
   reg  [7:0] t1_div;
   reg  [7:0] t2_ctrl;
   reg  [7:0] t2_div;
   reg  [2:0] irq_status;
   reg  [2:0] irq_mask;
   reg        ext_clock_q;
   reg  [2:0] wave_q;
   reg  [2:0] irq_event;
   wire [4:0] div_code [0:2];
   wire [2:0] wave_shape;
   wire [2:0] sync_hold;
   wire [1:0] irq_edge [0:2];
   wire [2:0] irq_source;
   wire [2:0] src_tick;
   wire       timer0_clock_source;
   wire [1:0] timer0_reset_source;
   wire [1:0] timer0_start_source;
   wire       ext_rise;

   // ----------------------------------------------------------------------------
   // Field extraction
   // ----------------------------------------------------------------------------
   assign div_code[0]        = t0_div[4:0];            // [RULE1]
   assign div_code[1]        = t1_div[4:0];            // [RULE1]
   assign div_code[2]        = t2_div[4:0];            // [RULE1]
   assign wave_shape         = {t2_div[5], t1_div[5], t0_div[5]};  // [RULE2]
   assign timer0_reset_source = t0_src[1:0];
   assign timer0_start_source = t0_src[3:2];
   assign timer0_clock_source = t0_src[4];
   assign sync_hold          = {t0_src[6], t0_src[7], t0_src[5]};  // [RULE6]
   assign irq_edge[0]        = `EDGE_RISE;
   assign irq_edge[1]        = t1_ctrl[5:4];           // [RULE10]
   assign irq_edge[2]        = t2_ctrl[5:4];           // [RULE10]
   assign irq_source         = {t2_ctrl[6], t1_ctrl[6], 1'b1};     // [RULE11]
   assign pwm_select_out     = {t2_ctrl[7], t1_ctrl[7], 1'b0};     // [RULE12]

   // ----------------------------------------------------------------------------
   // Reset and start selection
   // ----------------------------------------------------------------------------
   // Timer 0 run/start follow the source fields; reserved code 11 keeps it idle.
   reg t0_run;
   reg t0_go;
   always @* begin
      case (timer0_reset_source)                       // [RULE3] [RULE14]
         `SEL_INTERNAL: t0_run = timer0_internal_reset_in;
         `SEL_EXTERNAL: t0_run = ext_reset_in;
         `SEL_EITHER:   t0_run = timer0_internal_reset_in & ext_reset_in;
         default:       t0_run = 1'b0;
      endcase
      case (timer0_start_source)                       // [RULE4] [RULE14]
         `SEL_INTERNAL: t0_go = timer0_internal_start_in;
         `SEL_EXTERNAL: t0_go = ext_start_in;
         `SEL_EITHER:   t0_go = timer0_internal_start_in | ext_start_in;
         default:       t0_go = 1'b0;
      endcase
   end

   // A set sync hold bit forces reset regardless of the other controls.
   assign run_enable_out = {t2_ctrl[0], t1_ctrl[0], t0_run} & ~sync_hold;  // [RULE7] [RULE8]
   assign go_out         = {t2_ctrl[2], t1_ctrl[2], t0_go} & run_enable_out; // [RULE9]

   // ----------------------------------------------------------------------------
   // Clock source and prescalers
   // ----------------------------------------------------------------------------
   // The external clock is sampled; its rising edge becomes a one-cycle enable.
   always @(posedge clk_in) begin
      if (reset_in) begin
         ext_clock_q <= 1'b0;
      end else begin
         ext_clock_q <= ext_clock_in;
      end
   end
   assign ext_rise    = ext_clock_in & ~ext_clock_q;
   assign src_tick[0] = timer0_clock_source ? ext_rise : 1'b1;  // [RULE5]
   assign src_tick[1] = 1'b1;
   assign src_tick[2] = 1'b1;

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : prescale
         reg  [DIV_WIDTH:0] count;
         wire [DIV_WIDTH:0] limit;
         // Codes above the largest ratio are reserved and treated as the largest.
         wire [4:0] code = (div_code[g] > `DIV_CODE_MAX) ? `DIV_CODE_MAX : div_code[g]; // [RULE14]
         assign limit = ({{DIV_WIDTH{1'b0}}, 1'b1} << code) - 1'b1;  // [RULE1]
         assign tick_out[g] = run_enable_out[g] & src_tick[g] & (count >= limit);
         always @(posedge clk_in) begin
            if (reset_in || !run_enable_out[g]) begin
               count <= {(DIV_WIDTH+1){1'b0}};
            end else if (src_tick[g]) begin
               if (count >= limit) begin
                  count <= {(DIV_WIDTH+1){1'b0}};
               end else begin
                  count <= count + 1'b1;
               end
            end
         end

         // Pulse shape holds high until the next divided tick, one divided period
         // when the datapath pulse arrives on a tick; square toggles per pulse.
         always @(posedge clk_in) begin
            if (reset_in || !run_enable_out[g]) begin
               wave_out[g]   <= 1'b0;
            end else if (wave_shape[g]) begin          // [RULE2]
               if (timer_wave_in[g] && go_out[g]) begin
                  wave_out[g] <= ~wave_out[g];
               end
            end else begin
               if (timer_wave_in[g] && go_out[g]) begin
                  wave_out[g] <= 1'b1;                 // [RULE13]
               end else if (tick_out[g]) begin
                  wave_out[g] <= 1'b0;                 // [RULE13]
               end
            end
         end

         // Interrupt event from counter stop or chosen output edges.
         wire rise = wave_out[g] & ~wave_q[g];
         wire fall = ~wave_out[g] & wave_q[g];
         always @* begin
            if (!irq_source[g]) begin
               irq_event[g] = counter_stop_in[g];      // [RULE11]
            end else begin
               case (irq_edge[g])                      // [RULE10]
                  `EDGE_FALL: irq_event[g] = fall;
                  `EDGE_RISE: irq_event[g] = rise;
                  `EDGE_BOTH: irq_event[g] = rise | fall;
                  default:    irq_event[g] = 1'b0;     // [RULE14]
               endcase
            end
         end
      end
   endgenerate

   always @(posedge clk_in) begin
      if (reset_in) begin
         wave_q <= 3'h0;
      end else begin
         wave_q <= wave_out;
      end
   end

   // ----------------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------------
   always @(posedge clk_in) begin
      if (reset_in) begin
         t0_div   <= `REG_RESET;                       // [RULE15]
         t0_src   <= `REG_RESET;                       // [RULE15]
         t1_ctrl  <= `REG_RESET;                       // [RULE15]
         t1_div   <= `REG_RESET;                       // [RULE15]
         t2_ctrl  <= `REG_RESET;                       // [RULE15]
         t2_div   <= `REG_RESET;                       // [RULE15]
         irq_mask <= 3'h0;
      end else if (wr_in) begin
         case (addr_in)                                // [RULE14]
            `ADDR_T0_DIV:   t0_div   <= wdata_in & `DIV_REG_MASK;
            `ADDR_T0_SRC:   t0_src   <= wdata_in & `SRC_REG_MASK;
            `ADDR_T1_CTRL:  t1_ctrl  <= wdata_in & `CTRL_REG_MASK;
            `ADDR_T1_DIV:   t1_div   <= wdata_in & `DIV_REG_MASK;
            `ADDR_T2_CTRL:  t2_ctrl  <= wdata_in & `CTRL_REG_MASK;
            `ADDR_T2_DIV:   t2_div   <= wdata_in & `DIV_REG_MASK;
            `ADDR_IRQ_MASK: irq_mask <= wdata_in[2:0];
            default: ;
         endcase
      end
   end

   // Status is sticky; a read clears it but an event in the same cycle survives.
   wire status_read = rd_in && (addr_in == `ADDR_IRQ_STATUS);
   always @(posedge clk_in) begin
      if (reset_in) begin
         irq_status <= 3'h0;
      end else if (status_read) begin
         irq_status <= irq_event;
      end else begin
         irq_status <= irq_status | irq_event;
      end
   end
   assign irq_out = |(irq_status & irq_mask);

   always @(posedge clk_in) begin
      if (reset_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         case (addr_in)
            `ADDR_T0_DIV:     rdata_out <= t0_div;
            `ADDR_T0_SRC:     rdata_out <= t0_src;
            `ADDR_T1_CTRL:    rdata_out <= t1_ctrl;
            `ADDR_T1_DIV:     rdata_out <= t1_div;
            `ADDR_T2_CTRL:    rdata_out <= t2_ctrl;
            `ADDR_T2_DIV:     rdata_out <= t2_div;
            `ADDR_IRQ_STATUS: rdata_out <= {5'h00, irq_status};
            `ADDR_IRQ_MASK:   rdata_out <= {5'h00, irq_mask};
            default:          rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

endmodule // timer_cfg

// ---- bench/timer_cfg_asserts.sv ----
// Concurrent checks on the ports of the timer configuration bank.
// Assumes the bank's offsets: 1 source and holds, 2 and 4 timer controls.
// ----------------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------------
module timer_cfg_asserts (
   input wire logic       clk_in,          // clock
   input wire logic       reset_in,        // reset
   input wire logic [3:0] addr_in,         // address
   input wire logic [7:0] wdata_in,        // write data
   input wire logic       wr_in,           // write strobe
   input wire logic       rd_in,           // read strobe
   input wire logic [7:0] rdata_out,       // read data
   input wire logic [2:0] run_enable_out,  // out of reset
   input wire logic [2:0] go_out,          // counting
   input wire logic [2:0] pwm_select_out,  // pwm mode
   input wire logic [2:0] wave_out,        // outputs
   input wire logic       irq_out          // interrupt
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside read slot");
   unmapped_rd_a: assert property (rd_in && addr_in[3] |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   pwm1_wr_a: assert property (wr_in && addr_in == 4'h2 |=> pwm_select_out[1] == $past(wdata_in[7]))
      else $error("timer 1 mode wrong");
   pwm2_wr_a: assert property (wr_in && addr_in == 4'h4 |=> pwm_select_out[2] == $past(wdata_in[7]))
      else $error("timer 2 mode wrong");
   pwm0_zero_a: assert property (pwm_select_out[0] == 1'b0)
      else $error("timer 0 mode set");
   run1_off_a: assert property (wr_in && addr_in == 4'h2 && !wdata_in[0] |=> !run_enable_out[1])
      else $error("timer 1 not held");
   go1_off_a: assert property (wr_in && addr_in == 4'h2 && !wdata_in[2] |=> !go_out[1])
      else $error("timer 1 not stopped");
   hold1_a: assert property (wr_in && addr_in == 4'h1 && wdata_in[7] |=> !run_enable_out[1])
      else $error("timer 1 hold ignored");
   hold2_a: assert property (wr_in && addr_in == 4'h1 && wdata_in[6] |=> !run_enable_out[2])
      else $error("timer 2 hold ignored");
   rst_clear_a: assert property ($fell(reset_in) |-> run_enable_out[2:1] == 2'b00 && wave_out == 3'b000 && !irq_out)
      else $error("state not cleared by reset");
   cover property (rd_in && addr_in == 4'h6);
   cover property (irq_out);
   cover property (wr_in && addr_in == 4'h1 && wdata_in[7]);
endmodule // timer_cfg_asserts

bind timer_cfg timer_cfg_asserts chk_u (.*);

// ---- bench/timer_cfg_test.sv ----
// Self-checking bench for the timer configuration bank.
// Assumes the register offsets of the bank and a free external clock of four cycles.
module timer_cfg_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, reset_in = 1, wr_in = 0, rd_in = 0, ext_clock_in = 0, ext_ph = 0;
   logic ext_reset_in = 0, ext_start_in = 0, timer0_internal_reset_in = 0;
   logic timer0_internal_start_in = 0, irq_out;
   logic [3:0] addr_in = 0;
   logic [7:0] wdata_in = 0, rdata_out;
   logic [2:0] counter_stop_in = 0, timer_wave_in = 0, tick_out, run_enable_out, go_out;
   logic [2:0] pwm_select_out, wave_out;
   int n_fail = 0, n_compared = 0, cycles = 0;
   timer_cfg #(.DIV_WIDTH(16)) dut_u (.*);
   initial forever #5 clk_in = ~clk_in;
   // The external clock is slower than half the master clock, as the divider needs.
   always @(posedge clk_in) {ext_clock_in, ext_ph} <= {ext_clock_in, ext_ph} + 2'd1;
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         finish_test();
      end
   end
   task automatic finish_test;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step;
      @(posedge clk_in);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      check(rdata_out, exp);
   endtask
   task automatic gap(input int b, input int exp);
      int n;
      n = 0;
      while (!tick_out[b] && n < 200) begin
         step();
         n++;
      end
      n = 0;
      do begin
         step();
         n++;
      end while (!tick_out[b] && n < 200);
      check(n[7:0], exp[7:0]);
   endtask
   task automatic t_regs;
      logic [7:0] m [6] = '{8'h3F, 8'hFF, 8'hF5, 8'h3F, 8'hF5, 8'h3F};
      for (int a = 0; a < 9; a++) rd(a[3:0], 8'h00);
      for (int a = 0; a < 6; a++) begin
         wr(a[3:0], 8'hFF);
         rd(a[3:0], m[a]);
         wr(a[3:0], 8'h00);
      end
      wr(4'hC, 8'hFF);
      rd(4'hC, 8'h00);
   endtask
   task automatic t_timer0;
      logic [1:0] s, v;
      for (int i = 0; i < 12; i++) begin
         s = i[3:2];
         v = i[1:0];
         wr(4'h1, {6'h0, s});
         {ext_reset_in, timer0_internal_reset_in} <= v;
         step();
         check(run_enable_out[0], s == 0 ? v[0] : s == 1 ? v[1] : &v);
         wr(4'h1, {4'h0, s, 2'h0});
         timer0_internal_reset_in <= 1'b1;
         ext_reset_in <= 1'b0;
         {ext_start_in, timer0_internal_start_in} <= v;
         step();
         check(go_out[0], s == 0 ? v[0] : s == 1 ? v[1] : |v);
      end
      wr(4'h1, 8'h20);
      check(run_enable_out[0], 1'b0);
      wr(4'h1, 8'h00);
      check(run_enable_out[0], 1'b1);
   endtask
   task automatic t_timer12;
      for (int t = 1; t < 3; t++) begin
         wr(2 * t, 8'h85);
         check({run_enable_out[t], go_out[t], pwm_select_out[t]}, 8'h07);
         wr(4'h1, t == 1 ? 8'h80 : 8'h40);
         check(run_enable_out[t], 1'b0);
         wr(4'h1, 8'h00);
         wr(2 * t, 8'h04);
         check({run_enable_out[t], go_out[t], pwm_select_out[t]}, 8'h00);
         wr(2 * t, 8'h01);
         check({run_enable_out[t], go_out[t]}, 8'h02);
      end
   endtask
   task automatic t_ticks;
      int c [4] = '{0, 1, 2, 4};
      wr(4'h2, 8'h05);
      foreach (c[k]) begin
         wr(4'h3, c[k][7:0]);
         gap(1, 1 << c[k]);
      end
      wr(4'h0, 8'h00);
      gap(0, 1);
      wr(4'h1, 8'h10);
      gap(0, 4);
      wr(4'h0, 8'h01);
      gap(0, 8);
      wr(4'h1, 8'h00);
   endtask
   task automatic t_wave_irq;
      logic w, x;
      int n;
      int ec [6] = '{1, 1, 0, 0, 2, 2};
      wr(4'h4, 8'h05);
      wr(4'h5, 8'h01);
      n = 0;
      while (!tick_out[2] && n < 200) begin
         step();
         n++;
      end
      timer_wave_in <= 3'b100;
      step();
      timer_wave_in <= 3'b000;
      n = 0;
      for (int k = 0; k < 10; k++) begin
         n += wave_out[2];
         step();
      end
      check(n[7:0], 8'h02);
      w = 1'b0;
      wr(4'h3, 8'h21);
      wr(4'h7, 8'h02);
      foreach (ec[i]) begin
         int e;
         e = ec[i];
         wr(4'h2, 8'h45 | (e << 4));
         timer_wave_in <= 3'b010;
         step();
         timer_wave_in <= 3'b000;
         repeat (3) step();
         w = ~w;
         x = (e == 2) || (e == 1 && w) || (e == 0 && !w);
         check(wave_out[1], w);
         check(irq_out, x);
         rd(4'h6, {6'h0, x, 1'b0});
         check(irq_out, 1'b0);
      end
      wr(4'h7, 8'h00);
      wr(4'h2, 8'h05);
      counter_stop_in <= 3'b010;
      step();
      counter_stop_in <= 3'b000;
      step();
      check(irq_out, 1'b0);
      rd(4'h6, 8'h02);
   endtask
   initial begin
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      step();
      t_regs();
      t_timer0();
      t_timer12();
      t_ticks();
      t_wave_irq();
      finish_test();
   end
endmodule // timer_cfg_test
